// File: hw/bgcr_cfg.svh
// Offsets, field positions, reset values and timing counts for the boot and global configuration register
`ifndef BGCR_CFG_SVH
`define BGCR_CFG_SVH
`define BGCR_OFF_BOOT_CFG 12'h050
`define BGCR_BIT_PKG 9
`define BGCR_BIT_FIXED_ONE 8
`define BGCR_BIT_HDLC 7
`define BGCR_BIT_CAN 6
`define BGCR_BIT_ADC 5
`define BGCR_BIT_DBG 4
`define BGCR_BIT_FILT 3
`define BGCR_BIT_SPI 2
`define BGCR_WR_MASK 16'h003F
`define BGCR_RESET_BASE 16'h0100
`define BGCR_ADC_START_NS 1000000
`define BGCR_CLK_NS 8
`define BGCR_ADC_START_CYC ((`BGCR_ADC_START_NS + `BGCR_CLK_NS - 1) / `BGCR_CLK_NS)
`endif

// File: hw/bgcr_pkg.sv
// Types shared by the boot and global configuration register block
package bgcr_pkg;
    // Boot memory selection codes
    typedef enum logic [1:0] {
        BGCR_BOOT_FLASH = 2'b00,
        BGCR_BOOT_RSVD = 2'b01,
        BGCR_BOOT_RAM = 2'b10,
        BGCR_BOOT_EXT = 2'b11
    } bgcr_boot_e;
    // Write channel progress of the bus slave
    typedef enum logic [1:0] {
        BGCR_WR_IDLE = 2'b00,
        BGCR_WR_RESP = 2'b01
    } bgcr_wr_e;
endpackage

// File: hw/bgcr_sync2.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
module bgcr_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic din,
    output logic dout
);
    logic meta_reg; // First stage, read by the second stage only

    // Two stages to settle metastability
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// File: hw/bgcr_alias_map.sv
// Decodes the boot selection into an alias choice for address zero, one-hot except for the reserved code
`timescale 1ns/1ns
module bgcr_alias_map (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] boot_sel,
    output logic alias_flash,
    output logic alias_ram,
    output logic alias_ext
);
    // Registered decode; the reserved code aliases nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alias_flash <= 1'b1;
            alias_ram <= 1'b0;
            alias_ext <= 1'b0;
        end else begin
            alias_flash <= (boot_sel == bgcr_pkg::BGCR_BOOT_FLASH);
            alias_ram <= (boot_sel == bgcr_pkg::BGCR_BOOT_RAM);
            alias_ext <= (boot_sel == bgcr_pkg::BGCR_BOOT_EXT);
        end
    end
endmodule

// File: hw/bgcr_top.sv
// Boot and global configuration register with an AXI4-Lite slave
`timescale 1ns/1ns
`include "bgcr_cfg.svh"
module bgcr_top #(
    parameter logic PKG_SMALL = 1'b0, // Package option strap
    parameter logic HDLC_FITTED = 1'b1, // HDLC option
    parameter logic CAN_FITTED = 1'b1, // CAN option
    parameter int ADDR_W = 12 // Bus address width
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] boot_pins, // External boot strap pins
    input wire logic tap_boot_valid, // Test port boot programming strobe
    input wire logic [1:0] tap_boot_sel, // Test port boot choice
    input wire logic stop_mode, // Device in stop mode
    input wire logic debug_request_input, // Debug request pin
    input wire logic usb_standby, // USB bus in standby
    output logic alias_flash, // Flash aliased at zero
    output logic alias_ram, // RAM aliased at zero
    output logic alias_ext, // External memory aliased at zero
    output logic small_package_flag, // Unbonded pins forced idle
    output logic hdlc_enable, // HDLC controller enable
    output logic can_enable, // CAN controller enable
    output logic adc_analog_on, // Converter analog power
    output logic stop_wake, // Ends stop mode, restarts clocks
    output logic standby_filter_on, // Transceiver filter active
    output logic serial_port0_owner, // Serial controller owns P0 pins 0..3
    output logic uart_instance_three_i2c_instance_one_owner // UART three and I2C one own those pins
);
    // Refuse address widths below 8 or above 32 bits
    if (ADDR_W < 8 || ADDR_W > 32) begin
        $error("ADDR_W out of range");
    end

    // Word index of the register, sized to the word part of the address
    localparam logic [ADDR_W-3:0] OFF_WORD = (ADDR_W-2)'(`BGCR_OFF_BOOT_CFG >> 2);

    // Synchronised external inputs
    logic [1:0] boot_pins_s;
    logic dbg_req_s;
    logic stop_s;
    logic standby_s;
    logic tap_valid_s;
    logic [1:0] tap_sel_s; // Test port boot choice after two stages

    // Boot pins and other pins cross in through two stages each
    bgcr_sync2 u_sync_b0 (.aclk(aclk), .aresetn(aresetn), .din(boot_pins[0]), .dout(boot_pins_s[0]));
    bgcr_sync2 u_sync_b1 (.aclk(aclk), .aresetn(aresetn), .din(boot_pins[1]), .dout(boot_pins_s[1]));
    bgcr_sync2 u_sync_dbg (.aclk(aclk), .aresetn(aresetn), .din(debug_request_input), .dout(dbg_req_s));
    bgcr_sync2 u_sync_stop (.aclk(aclk), .aresetn(aresetn), .din(stop_mode), .dout(stop_s));
    bgcr_sync2 u_sync_stby (.aclk(aclk), .aresetn(aresetn), .din(usb_standby), .dout(standby_s));
    bgcr_sync2 u_sync_tap (.aclk(aclk), .aresetn(aresetn), .din(tap_boot_valid), .dout(tap_valid_s));
    // The choice lines take the same two stages, so they reach the edge detect in the same cycle as the strobe
    bgcr_sync2 u_sync_ts0 (.aclk(aclk), .aresetn(aresetn), .din(tap_boot_sel[0]), .dout(tap_sel_s[0]));
    bgcr_sync2 u_sync_ts1 (.aclk(aclk), .aresetn(aresetn), .din(tap_boot_sel[1]), .dout(tap_sel_s[1]));

    // Register state
    logic [1:0] boot_reg; // Boot selection field
    logic [3:0] ctrl_reg; // Converter, debug wake, filter, port select
    logic [1:0] strap_cnt_reg; // Counts edges after reset until pins settle
    logic strap_done_reg; // Strap capture finished
    logic tap_prev_reg; // Previous test port strobe for edge detect

    // Bus handshake state
    logic aw_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic w_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [15:0] read_word;

    // Assembled register view; reserved bits fixed
    always_comb begin
        read_word = `BGCR_RESET_BASE;
        read_word[`BGCR_BIT_PKG] = PKG_SMALL;
        read_word[`BGCR_BIT_HDLC] = HDLC_FITTED;
        read_word[`BGCR_BIT_CAN] = CAN_FITTED;
        read_word[5:2] = ctrl_reg;
        read_word[1:0] = boot_reg;
    end

    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = (awaddr_reg[ADDR_W-1:2] == OFF_WORD);
    assign rd_hit = (s_axi_araddr[ADDR_W-1:2] == OFF_WORD);

    // Strap capture: the pins pass two stages, so wait three edges after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            strap_done_reg <= (strap_cnt_reg == 2'h2);
        end
    end

    // Test port strobe edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_prev_reg <= 1'b0;
        end else begin
            tap_prev_reg <= tap_valid_s;
        end
    end

    // Boot field: strap, then test port or software may replace it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_reg <= 2'h0;
        end else if (!strap_done_reg && strap_cnt_reg == 2'h2) begin
            boot_reg <= boot_pins_s;
        end else if (tap_valid_s && !tap_prev_reg) begin
            boot_reg <= tap_sel_s;
        end else if (wr_fire && wr_hit && wstrb_reg[0]) begin
            boot_reg <= wdata_reg[1:0];
        end
    end

    // Writable controls; only byte lane 0 carries them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= 4'h0;
        end else if (wr_fire && wr_hit && wstrb_reg[0]) begin
            ctrl_reg <= wdata_reg[5:2];
        end
    end

    // Write address channel: hold one address until the write fires and raises the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // Write data channel, independent of address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Readies come from flops; dropped while a channel holds an item
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response; unmapped address answers DECERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h3;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel: one read at a time, answered the edge after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? {16'h0, read_word} : 32'h0;
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h3;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Alias decode for the memory map at address zero
    bgcr_alias_map u_alias (
        .aclk(aclk),
        .aresetn(aresetn),
        .boot_sel(boot_reg),
        .alias_flash(alias_flash),
        .alias_ram(alias_ram),
        .alias_ext(alias_ext)
    );

    // Fixed options and control outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            small_package_flag <= 1'b0;
            hdlc_enable <= 1'b0;
            can_enable <= 1'b0;
            adc_analog_on <= 1'b0;
            stop_wake <= 1'b0;
            standby_filter_on <= 1'b0;
            serial_port0_owner <= 1'b0;
            uart_instance_three_i2c_instance_one_owner <= 1'b1;
        end else begin
            small_package_flag <= PKG_SMALL;
            hdlc_enable <= HDLC_FITTED;
            can_enable <= CAN_FITTED;
            adc_analog_on <= ctrl_reg[`BGCR_BIT_ADC-2];
            // A disabled wake leaves the request unseen
            stop_wake <= ctrl_reg[`BGCR_BIT_DBG-2] && stop_s && dbg_req_s;
            standby_filter_on <= ctrl_reg[`BGCR_BIT_FILT-2] && standby_s;
            serial_port0_owner <= ctrl_reg[`BGCR_BIT_SPI-2];
            uart_instance_three_i2c_instance_one_owner <= !ctrl_reg[`BGCR_BIT_SPI-2];
        end
    end

    // Helper: cycles since converter power-up, read only by an assertion
    logic [17:0] adc_up_cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn || !adc_analog_on) begin
            adc_up_cnt_reg <= 18'h0;
        end else if (adc_up_cnt_reg != 18'h3FFFF) begin
            adc_up_cnt_reg <= adc_up_cnt_reg + 18'h1;
        end
    end

    a_strap_capture: assert property (@(posedge aclk) disable iff (!aresetn)
        (!strap_done_reg && strap_cnt_reg == 2'h2) |=> boot_reg == $past(boot_pins_s))
        else $error("boot field missed strap");
    a_sw_boot_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_fire && wr_hit && wstrb_reg[0] && strap_done_reg && !(tap_valid_s && !tap_prev_reg))
        |=> boot_reg == $past(wdata_reg[1:0]))
        else $error("boot write lost");
    a_alias_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        (boot_reg == 2'b10) |=> alias_ram && !alias_flash)
        else $error("alias wrong");
    a_fixed_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        read_word[15:6] == {6'h0, PKG_SMALL, 1'b1, HDLC_FITTED, CAN_FITTED})
        else $error("fixed bits changed");
    a_ctrl_reset: assert property (@(posedge aclk)
        !aresetn |=> ctrl_reg == 4'h0 && boot_reg == 2'h0)
        else $error("reset value wrong");
    a_adc_power: assert property (@(posedge aclk) disable iff (!aresetn)
        ctrl_reg[3] |=> adc_analog_on)
        else $error("converter not powered");
    a_stop_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_reg[2] && stop_s && dbg_req_s) |=> stop_wake)
        else $error("debug wake missed");
    a_stop_ignore: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_reg[2]) |=> !stop_wake)
        else $error("debug request not ignored");
    a_filter_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        standby_filter_on |-> $past(standby_s) && $past(ctrl_reg[1]))
        else $error("filter outside standby");
    a_pin_owner: assert property (@(posedge aclk) disable iff (!aresetn)
        serial_port0_owner != uart_instance_three_i2c_instance_one_owner)
        else $error("pin ownership clash");
    a_adc_count: assert property (@(posedge aclk) disable iff (!aresetn)
        !adc_analog_on |=> adc_up_cnt_reg == 18'h0)
        else $error("startup count not cleared");
endmodule

// File: tb/bgcr_tb_top.sv
// Self-checking bench for the boot and global configuration register
`timescale 1ns/1ns
`include "bgcr_cfg.svh"
module bgcr_tb_top;
    localparam logic P_PKG = 1'h1; // Small package, so the flag is seen set
    localparam logic P_HDLC = 1'h0; // HDLC absent, so a zero option is seen
    localparam logic P_CAN = 1'h1; // CAN fitted
    localparam logic [11:0] OFF = `BGCR_OFF_BOOT_CFG; // Register byte address
    localparam int LIMIT = 200; // Bound on every handshake wait
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, boot_pins, tap_boot_sel;
    logic tap_boot_valid, stop_mode, debug_request_input, usb_standby;
    logic alias_flash, alias_ram, alias_ext, small_package_flag, hdlc_enable, can_enable;
    logic adc_analog_on, stop_wake, standby_filter_on, serial_port0_owner, uart_instance_three_i2c_instance_one_owner;
    logic [15:0] mdl; // Behavioural copy of the register
    logic [31:0] rd, d; // Last read data and write payload
    logic [1:0] rs; // Last response code
    integer seed = 53016; // Fixed seed keeps runs repeatable
    int failures, checked;

    bgcr_top #(.PKG_SMALL(P_PKG), .HDLC_FITTED(P_HDLC), .CAN_FITTED(P_CAN), .ADDR_W(12)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .boot_pins, .tap_boot_valid, .tap_boot_sel, .stop_mode, .debug_request_input, .usb_standby,
        .alias_flash, .alias_ram, .alias_ext, .small_package_flag, .hdlc_enable, .can_enable,
        .adc_analog_on, .stop_wake, .standby_filter_on, .serial_port0_owner, .uart_instance_three_i2c_instance_one_owner);

    // Free-running 125 MHz clock
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end

    // Closing report, the single exit of the run
    task automatic wrap_up;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Compare a bus result with the model
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare a port level with the model
    task automatic chk_pin(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write cycle: both channels offered together, each dropped once taken
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] dv, input logic [3:0] sb, input logic [1:0] er);
        int n;
        logic aw_left, w_left;
        n = 0;
        aw_left = 1'h1;
        w_left = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= dv;
        s_axi_wstrb <= sb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while ((aw_left || w_left) && n < LIMIT) begin
            @(posedge aclk);
            n++;
            if (aw_left && s_axi_awready) begin
                aw_left = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w_left && s_axi_wready) begin
                w_left = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_bvalid && n < LIMIT);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= LIMIT) begin
            failures++;
            wrap_up;
        end
        // Only lane 0 of the mapped word commits, and only its writable bits
        if (a == OFF && sb[0]) begin
            mdl[5:0] = dv[5:0];
        end
        chk_reg({30'h0, rs}, {30'h0, er});
        @(posedge aclk);
    endtask

    // Read cycle; ready is held until the data is seen
    task automatic reg_rd(input logic [11:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < LIMIT);
        s_axi_arvalid <= 1'h0;
        do begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < LIMIT);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= LIMIT) begin
            failures++;
            wrap_up;
        end
        @(posedge aclk);
    endtask

    // Read the register back and compare every bit with the model
    task automatic rd_chk;
        reg_rd(OFF);
        chk_reg(rd, {16'h0000, mdl});
        chk_reg({30'h0, rs}, 32'h0);
    endtask

    // Compare every output except stop_wake with what the model bits mean
    task automatic chk_outs;
        chk_pin(alias_flash, mdl[1:0] == 2'h0);
        chk_pin(alias_ram, mdl[1:0] == 2'h2);
        chk_pin(alias_ext, mdl[1:0] == 2'h3);
        chk_pin(small_package_flag, P_PKG);
        chk_pin(hdlc_enable, P_HDLC);
        chk_pin(can_enable, P_CAN);
        chk_pin(adc_analog_on, mdl[5]);
        chk_pin(standby_filter_on, mdl[3] & usb_standby);
        chk_pin(serial_port0_owner, mdl[2]);
        chk_pin(uart_instance_three_i2c_instance_one_owner, !mdl[2]);
    endtask

    // Reset for 16 cycles, then let the strap capture land
    task automatic do_reset;
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (8) @(posedge aclk);
        mdl = {6'h00, P_PKG, 1'h1, P_HDLC, P_CAN, 4'h0, boot_pins};
    endtask

    // Synchronised inputs need a few cycles before outputs follow
    task automatic settle;
        repeat (8) @(posedge aclk);
    endtask

    // Main sequence
    initial begin
        failures = 0;
        checked = 0;
        aresetn = 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {tap_boot_valid, tap_boot_sel, stop_mode, debug_request_input, usb_standby} = '0;
        boot_pins = 2'($random(seed));
        do_reset;
        rd_chk;
        chk_outs;
        // Every boot code, with random data also hitting read-only and reserved bits
        for (int c = 3; c >= 0; c--) begin
            d = $random(seed);
            d[1:0] = c[1:0];
            reg_wr(OFF, d, 4'hF, 2'h0);
            rd_chk;
            chk_outs;
        end
        // Lane 0 disabled: nothing may change
        reg_wr(OFF, 32'h0000003F, 4'hE, 2'h0);
        rd_chk;
        // Unmapped word: decode error both ways, register untouched
        reg_wr(OFF + 12'h004, 32'h0000003F, 4'hF, 2'h3);
        reg_rd(OFF + 12'h004);
        chk_reg(rd, 32'h0);
        chk_reg({30'h0, rs}, 32'h3);
        rd_chk;
        // Converter up; no conversion result is relied on, so its start-up time never matters here
        reg_wr(OFF, 32'h00000020, 4'h1, 2'h0);
        settle;
        chk_outs;
        // Converter switched off before stop is entered
        reg_wr(OFF, 32'h00000000, 4'h1, 2'h0);
        // Debug request during stop, wake disabled then enabled
        stop_mode <= 1'h1;
        debug_request_input <= 1'h1;
        settle;
        chk_pin(adc_analog_on, 1'h0);
        chk_pin(stop_wake, 1'h0);
        reg_wr(OFF, 32'h00000010, 4'h1, 2'h0);
        settle;
        chk_pin(stop_wake, 1'h1);
        debug_request_input <= 1'h0;
        settle;
        chk_pin(stop_wake, 1'h0);
        stop_mode <= 1'h0;
        // Filter only acts while the bus is in standby
        reg_wr(OFF, 32'h00000008, 4'h1, 2'h0);
        settle;
        chk_outs;
        usb_standby <= 1'h1;
        settle;
        chk_outs;
        // Test port reprograms the boot choice
        tap_boot_sel <= 2'h3;
        repeat (4) @(posedge aclk);
        tap_boot_valid <= 1'h1;
        repeat (6) @(posedge aclk);
        tap_boot_valid <= 1'h0;
        repeat (6) @(posedge aclk);
        mdl[1:0] = 2'h3;
        rd_chk;
        chk_outs;
        // Second reset with other strap levels
        boot_pins <= ~boot_pins;
        do_reset;
        rd_chk;
        chk_outs;
        wrap_up;
    end
endmodule
